// file: shared/adc_ctl_pkg.sv
// constants of the dual converter mode and serial output control
// assumes a 125 MHz system clock sampling the conversion-select and serial clock pins
//
// Functional notes
// - select rising after edge ten, before fourteen: stay powered, abort, release outputs.
// - after fourteen cycles outputs stay driven until select rises or dual read ends.
// - two more cycles shift out two trailing zeros on each line.
// - fourteen further cycles put the other channel result on the same line.
// - line releases on falling edge thirty-two or earlier select rise.
// - normal mode, select rising between edges two and ten: partial power-down.
// - select rising before edge two is a glitch, mode unchanged.
// - partial power-down keeps only reference and its buffers powered.
// - dummy conversion past edge ten wakes partial within about 333 ns.
// - in partial, select rising before edge two powers down again at once.
// - in partial, select rising between edges two and ten gives full power-down.
// - full power-down switches off all analog parts including the reference.
// - waking from partial, hold returns to track after first serial edge.
// - select fall samples both inputs, starts conversion, drives both lines.
// - leading zero at select fall, second zero on edge one, then result MSB first.
// - results are straight binary, lowest code for most negative input.
package adc_ctl_pkg;

    // ========================================
    // widths and modes
    localparam int RESULT_BITS = 12;
    localparam int COUNT_BITS  = 6;
    localparam int WAKE_BITS   = 20;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PARTIAL,
        MODE_FULL
    } power_mode_t;

    // ========================================
    // serial clock edge counts
    localparam logic [5:0] EDGE_GLITCH_END = 6'h02;  // rises before this are glitches
    localparam logic [5:0] EDGE_POWER_KEEP = 6'h0A;  // rises at or after this keep power
    localparam logic [5:0] EDGE_HOLD_END   = 6'h0D;  // hold ends after this many falls
    localparam logic [5:0] EDGE_MSB_FIRST  = 6'h02;  // first line msb
    localparam logic [5:0] EDGE_LSB_FIRST  = 6'h0D;  // first line lsb
    localparam logic [5:0] EDGE_MSB_OTHER  = 6'h12;  // other channel msb
    localparam logic [5:0] EDGE_LSB_OTHER  = 6'h1D;  // other channel lsb
    localparam logic [5:0] EDGE_RELEASE    = 6'h20;  // line released on this fall

    // ========================================
    // timing
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int PARTIAL_WAKE_NS = 333;
    localparam int DEEP_WAKE_MS    = 6;
    localparam int PARTIAL_WAKE_CYCLES = (PARTIAL_WAKE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DEEP_WAKE_CYCLES    = (DEEP_WAKE_MS * 1000000) / CLOCK_PERIOD_NS;

endpackage : adc_ctl_pkg

// file: shared/edge_if.sv
// synchronised pin level with its edge pulses
// assumes one producer and one consumer on the system clock
`timescale 1ns/1ns
`default_nettype none
interface edge_if;
    logic level;
    logic rise;
    logic fall;
    modport source (output level, output rise, output fall);
    modport sink   (input  level, input  rise, input  fall);
endinterface : edge_if
`default_nettype wire

// file: core/pin_edge.sv
// two-flop synchroniser with edge detection for one pin
// assumes the pin is asynchronous to clock; level resets to RESET_LEVEL
`timescale 1ns/1ns
`default_nettype none
module pin_edge #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pin,
    edge_if.source    sync
);
    logic meta;
    logic stable;
    logic last;

    // ========================================
    // synchroniser chain, first flop read only by the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta   <= RESET_LEVEL;
            stable <= RESET_LEVEL;
            last   <= RESET_LEVEL;
        end else begin
            meta   <= pin;
            stable <= meta;
            last   <= stable;
        end
    end

    // edge pulses from the stable flops
    assign sync.level = stable;
    assign sync.rise  = stable & ~last;
    assign sync.fall  = ~stable & last;

endmodule : pin_edge
`default_nettype wire

// file: core/dual_adc_mode_ctl.sv
// power mode selection and dual serial output control of a two-channel converter
// assumes results arrive on the system clock; select and serial clock are raw pins
`timescale 1ns/1ns
`default_nettype none
module dual_adc_mode_ctl #(
    parameter int DEEP_WAKE = adc_ctl_pkg::DEEP_WAKE_CYCLES
) (
    input  wire logic                                clock,
    input  wire logic                                rst_n,
    input  wire logic                                select_n,
    input  wire logic                                sclk,
    input  wire logic [adc_ctl_pkg::RESULT_BITS-1:0] result_first,
    input  wire logic [adc_ctl_pkg::RESULT_BITS-1:0] result_second,
    output logic                                     serial_out_first,
    output logic                                     serial_out_first_oe_n,
    output logic                                     serial_out_second,
    output logic                                     serial_out_second_oe_n,
    output logic                                     sample_strobe,
    output logic                                     track_hold,
    output logic                                     analog_on,
    output logic                                     reference_on,
    output logic                                     powered_up,
    output logic [1:0]                               mode_state
);
    localparam int RB = adc_ctl_pkg::RESULT_BITS;
    localparam int CB = adc_ctl_pkg::COUNT_BITS;
    localparam int WB = adc_ctl_pkg::WAKE_BITS;
    localparam logic [WB-1:0] PARTIAL_LOAD = WB'(adc_ctl_pkg::PARTIAL_WAKE_CYCLES);
    localparam logic [WB-1:0] DEEP_LOAD    = WB'(DEEP_WAKE);

    edge_if sel_sync ();
    edge_if clk_sync ();

    adc_ctl_pkg::power_mode_t mode;
    adc_ctl_pkg::power_mode_t next_mode;
    logic          frame;     // select seen low
    logic          drive;     // data lines driven
    logic [CB-1:0] count;     // serial falling edges since select fell
    logic [RB-1:0] keep_a;
    logic [RB-1:0] keep_b;
    logic          waking;    // frame began outside normal mode
    logic          wake_edge; // first serial edge seen since select fell
    logic [WB-1:0] wake_count;

    // ========================================
    // pin synchronisers
    pin_edge #(.RESET_LEVEL(1'b1)) select_edge (
        .clock (clock),
        .rst_n (rst_n),
        .pin   (select_n),
        .sync  (sel_sync)
    );

    pin_edge #(.RESET_LEVEL(1'b0)) sclk_edge (
        .clock (clock),
        .rst_n (rst_n),
        .pin   (sclk),
        .sync  (clk_sync)
    );

    // ========================================
    // frame decode
    wire           start     = sel_sync.fall;
    wire           finish    = sel_sync.rise & frame;
    wire           shift     = clk_sync.fall & frame & ~sel_sync.rise;
    wire [CB-1:0]  count_inc = count + CB'(1);
    wire           at_end    = shift & (count_inc == adc_ctl_pkg::EDGE_RELEASE);
    wire           glitch    = count < adc_ctl_pkg::EDGE_GLITCH_END;
    wire           kept      = count >= adc_ctl_pkg::EDGE_POWER_KEEP;

    // bit to present after a serial falling edge, straight binary msb first
    function automatic logic pick(input logic [RB-1:0] own, input logic [RB-1:0] other,
                                  input logic [CB-1:0] n);
        logic [CB-1:0] ia;
        logic [CB-1:0] ib;
        ia = adc_ctl_pkg::EDGE_LSB_FIRST - n;
        ib = adc_ctl_pkg::EDGE_LSB_OTHER - n;
        if (n >= adc_ctl_pkg::EDGE_MSB_FIRST && n <= adc_ctl_pkg::EDGE_LSB_FIRST)
            pick = own[ia[3:0]];
        else if (n >= adc_ctl_pkg::EDGE_MSB_OTHER && n <= adc_ctl_pkg::EDGE_LSB_OTHER)
            pick = other[ib[3:0]];
        else
            pick = 1'b0;
    endfunction : pick

    // ========================================
    // mode choice at select rise
    always_comb begin
        next_mode = mode;
        if (finish && !glitch && !kept) begin
            case (mode)
                adc_ctl_pkg::MODE_NORMAL:  next_mode = adc_ctl_pkg::MODE_PARTIAL;
                adc_ctl_pkg::MODE_PARTIAL: next_mode = adc_ctl_pkg::MODE_FULL;
                adc_ctl_pkg::MODE_FULL:    next_mode = adc_ctl_pkg::MODE_FULL;
                default:                   next_mode = adc_ctl_pkg::MODE_NORMAL;
            endcase
        end else if (finish && kept) begin
            next_mode = adc_ctl_pkg::MODE_NORMAL;
        end
    end

    // mode register
    always_ff @(posedge clock) begin
        if (!rst_n) mode <= adc_ctl_pkg::MODE_NORMAL;
        else        mode <= next_mode;
    end

    // ========================================
    // frame, count and capture
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frame  <= 1'b0;
            count  <= '0;
            keep_a <= '0;
            keep_b <= '0;
        end else if (start) begin
            frame  <= 1'b1;
            count  <= '0;
            keep_a <= result_first;
            keep_b <= result_second;
        end else if (sel_sync.rise) begin
            frame  <= 1'b0;
        end else if (shift && count != adc_ctl_pkg::EDGE_RELEASE) begin
            count  <= count_inc;
        end
    end

    // ========================================
    // serial data lines
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            drive             <= 1'b0;
            serial_out_first  <= 1'b0;
            serial_out_second <= 1'b0;
        end else if (start) begin
            drive             <= 1'b1;
            serial_out_first  <= 1'b0;
            serial_out_second <= 1'b0;
        end else if (sel_sync.rise || at_end) begin
            drive             <= 1'b0;
        end else if (shift && drive) begin
            serial_out_first  <= pick(keep_a, keep_b, count_inc);
            serial_out_second <= pick(keep_b, keep_a, count_inc);
        end
    end

    assign serial_out_first_oe_n  = ~drive;
    assign serial_out_second_oe_n = ~drive;
    assign sample_strobe          = start;

    // ========================================
    // track and hold, wake timing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            track_hold <= 1'b0;
            waking     <= 1'b0;
            wake_edge  <= 1'b0;
            wake_count <= '0;
        end else if (start) begin
            track_hold <= 1'b1;
            waking     <= mode != adc_ctl_pkg::MODE_NORMAL;
            wake_edge  <= 1'b0;
            wake_count <= (mode == adc_ctl_pkg::MODE_FULL) ? DEEP_LOAD :
                          (mode == adc_ctl_pkg::MODE_PARTIAL) ? PARTIAL_LOAD : '0;
        end else begin
            if (sel_sync.rise)
                track_hold <= 1'b0;
            else if (waking && !wake_edge && (clk_sync.rise || clk_sync.fall))
                track_hold <= 1'b0;
            else if (!waking && clk_sync.rise && count >= adc_ctl_pkg::EDGE_HOLD_END)
                track_hold <= 1'b0;
            if (clk_sync.rise || clk_sync.fall)
                wake_edge <= 1'b1;
            if (wake_count != '0)
                wake_count <= wake_count - WB'(1);
        end
    end

    // power switches: a frame wakes circuits until select rises
    assign analog_on    = (mode == adc_ctl_pkg::MODE_NORMAL) | frame;
    assign reference_on = (mode != adc_ctl_pkg::MODE_FULL) | frame;
    assign powered_up   = analog_on & (wake_count == '0);
    assign mode_state   = mode;

    // ========================================
    // checks
    partial_entry_a: assert property (@(posedge clock) disable iff (!rst_n)
        finish && mode == adc_ctl_pkg::MODE_NORMAL && count >= 6'h02 && count < 6'h0A
        |=> mode == adc_ctl_pkg::MODE_PARTIAL)
        else $error("normal mode did not enter partial power-down");

    full_entry_a: assert property (@(posedge clock) disable iff (!rst_n)
        finish && mode == adc_ctl_pkg::MODE_PARTIAL && count >= 6'h02 && count < 6'h0A
        |=> mode == adc_ctl_pkg::MODE_FULL)
        else $error("partial mode did not enter full power-down");

    glitch_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
        finish && count < 6'h02 |=> $stable(mode))
        else $error("glitch on select changed the mode");

    keep_power_a: assert property (@(posedge clock) disable iff (!rst_n)
        finish && count >= 6'h0A |=> mode == adc_ctl_pkg::MODE_NORMAL && serial_out_first_oe_n)
        else $error("late select rise did not keep power and release lines");

    drive_start_a: assert property (@(posedge clock) disable iff (!rst_n)
        start |=> !serial_out_first_oe_n && !serial_out_second_oe_n && !serial_out_first && track_hold)
        else $error("select fall did not drive zero and hold");

    release_end_a: assert property (@(posedge clock) disable iff (!rst_n)
        shift && count == 6'h1F |=> serial_out_first_oe_n)
        else $error("line not released on falling edge thirty-two");

    msb_out_a: assert property (@(posedge clock) disable iff (!rst_n)
        shift && drive && count == 6'h01 |=> serial_out_first == keep_a[11] && serial_out_second == keep_b[11])
        else $error("msb not presented on second falling edge");

    other_msb_a: assert property (@(posedge clock) disable iff (!rst_n)
        shift && drive && count == 6'h11 |=> serial_out_first == keep_b[11])
        else $error("other channel msb missing on the first line");

    trail_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        shift && drive && (count == 6'h0D || count == 6'h0E) |=> !serial_out_first && !serial_out_second)
        else $error("trailing zero missing");

    full_ref_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        mode == adc_ctl_pkg::MODE_FULL && !frame |-> !reference_on && !analog_on)
        else $error("reference on in full power-down");

    partial_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
        start && mode == adc_ctl_pkg::MODE_PARTIAL |-> ##[1:43] (powered_up || !frame))
        else $error("partial wake took longer than its delay");

    wake_track_a: assert property (@(posedge clock) disable iff (!rst_n)
        waking && !wake_edge && (clk_sync.rise || clk_sync.fall) && frame && !sel_sync.rise |=> !track_hold)
        else $error("hold not released on first edge while waking");

endmodule : dual_adc_mode_ctl
`default_nettype wire

// file: dv/host_port_model.sv
// host serial port model: drives select and serial clock, reads both data lines
// assumes the serial clock idles low and stands still between frames
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
    input  wire logic        clock,
    output logic             select_n,
    output logic             sclk,
    input  wire logic        data_a,
    input  wire logic        oe_a_n,
    input  wire logic        data_b,
    input  wire logic        oe_b_n,
    input  wire logic        powered_up,
    input  wire logic        track_hold,
    input  wire logic [1:0]  mode_state,
    input  wire logic        analog_on,
    input  wire logic        reference_on,
    output logic             done,
    output logic [31:0]      got_a,
    output logic [31:0]      got_b,
    output logic [7:0]       got_flags,
    output logic [1:0]       got_mode
);
    // ========================================
    // wire levels: a released line shows a level that flips every cycle
    logic noise;
    wire  line_a = oe_a_n ? noise : data_a;
    wire  line_b = oe_b_n ? noise : data_b;

    initial begin
        select_n = 1'h1;
        sclk     = 1'h0;
        done     = 1'h0;
        noise    = 1'h0;
    end

    // toggling pattern for released lines
    always @(posedge clock) begin
        noise <= ~noise;
    end

    // ========================================
    // one frame of n serial falls; select rises after the last fall
    task automatic frame(input int n);
        got_a     = 32'h0000_0000;
        got_b     = 32'h0000_0000;
        got_flags = 8'h40;
        select_n  <= 1'h0; // nonblocking: no race with the sampling edge
        #63;
        for (int i = 0; i < n; i++) begin
            sclk  <= 1'h1; // may land on a clock edge, so nonblocking
            got_a = {got_a[30:0], line_a}; // read on the rising edge
            got_b = {got_b[30:0], line_b};
            if (i == 0) got_flags[7] = powered_up;
            if (i == 1) got_flags[6] = track_hold;
            #62;
            sclk <= 1'h0;
            #63;
        end
        got_flags[5:4] = {oe_a_n, oe_b_n};
        select_n <= 1'h1;
        #200;
        got_flags[3:2] = {oe_a_n, oe_b_n};
        got_flags[1:0] = {analog_on, reference_on};
        got_mode       = mode_state;
        @(posedge clock) done <= 1'h1;
        @(posedge clock) done <= 1'h0;
    endtask : frame
endmodule : host_port_model
`default_nettype wire

// file: dv/dual_adc_power_mode_serial_tb.sv
// self-checking bench of the converter mode and serial output control
// assumes host_port_model and the design sources are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module dual_adc_power_mode_serial_tb;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
        logic [7:0]  flags;
        logic [1:0]  mode;
        logic        hold_chk;
    } note_t;

    logic        clock, rst_n, select_n, sclk, done;
    logic [11:0] res_a, res_b;
    logic        sd_a, oe_a_n, sd_b, oe_b_n, strobe, hold, an_on, ref_on, up;
    logic [1:0]  mode;
    logic [31:0] got_a, got_b, seed;
    logic [7:0]  got_flags, mask;
    logic [1:0]  got_mode;
    int          error_cnt, comparisons, frames, strobes;
    note_t       notes[$];
    adc_ctl_pkg::power_mode_t cur;

    // ========================================
    // clock, design and host
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    dual_adc_mode_ctl #(.DEEP_WAKE(50)) dut_u (
        .clock(clock), .rst_n(rst_n), .select_n(select_n), .sclk(sclk),
        .result_first(res_a), .result_second(res_b),
        .serial_out_first(sd_a), .serial_out_first_oe_n(oe_a_n),
        .serial_out_second(sd_b), .serial_out_second_oe_n(oe_b_n),
        .sample_strobe(strobe), .track_hold(hold), .analog_on(an_on),
        .reference_on(ref_on), .powered_up(up), .mode_state(mode)
    );

    host_port_model host_u (
        .clock(clock), .select_n(select_n), .sclk(sclk),
        .data_a(sd_a), .oe_a_n(oe_a_n), .data_b(sd_b), .oe_b_n(oe_b_n),
        .powered_up(up), .track_hold(hold), .mode_state(mode),
        .analog_on(an_on), .reference_on(ref_on), .done(done),
        .got_a(got_a), .got_b(got_b), .got_flags(got_flags), .got_mode(got_mode)
    );

    // ========================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic complete_run;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // one frame: note the expected result, then let the host run it
    task automatic run(input int n, input adc_ctl_pkg::power_mode_t after);
        note_t e;
        logic [31:0] fa, fb;
        seed = lfsr_next(seed);
        @(negedge clock);
        res_a <= seed[11:0];
        res_b <= seed[27:16];
        fa = {2'h0, seed[11:0], 4'h0, seed[27:16], 2'h0};
        fb = {2'h0, seed[27:16], 4'h0, seed[11:0], 2'h0};
        e.a = fa >> (32 - n);
        e.b = fb >> (32 - n);
        e.flags = {cur == adc_ctl_pkg::MODE_NORMAL, !(cur == adc_ctl_pkg::MODE_PARTIAL && n >= 2),
                   (n == 32) ? 2'h3 : 2'h0, 2'h3,
                   after == adc_ctl_pkg::MODE_NORMAL, after != adc_ctl_pkg::MODE_FULL};
        e.mode = after;
        e.hold_chk = (cur != adc_ctl_pkg::MODE_FULL) || (n < 2);
        notes.push_back(e);
        cur = after;
        frames++;
        host_u.frame(n);
    endtask : run

    // strobe pulses, one per frame
    always @(posedge clock) begin
        if (strobe === 1'h1) strobes++;
    end

    // ========================================
    // monitor: oldest note against each finished frame
    always @(posedge clock) begin
        note_t e;
        if (done === 1'h1) begin
            e = notes.pop_front();
            mask = e.hold_chk ? 8'h00 : 8'h40;
            `CHK(got_a, e.a)
            `CHK(got_b, e.b)
            `CHK(got_flags | mask, e.flags | mask)
            `CHK(got_mode, e.mode)
        end
    end

    // ========================================
    // main sequence
    initial begin
        rst_n = 1'h0;
        res_a = 12'h000;
        res_b = 12'h000;
        seed = 32'hb0da_2d71;
        error_cnt = 0;
        comparisons = 0;
        frames = 0;
        strobes = 0;
        cur = adc_ctl_pkg::MODE_NORMAL;
        repeat (4) @(posedge clock);
        @(negedge clock) rst_n <= 1'h1;
        repeat (4) @(negedge clock);
        `CHK({mode, oe_a_n, oe_b_n}, 4'h3)
        run(14, adc_ctl_pkg::MODE_NORMAL);
        run(16, adc_ctl_pkg::MODE_NORMAL);
        run(32, adc_ctl_pkg::MODE_NORMAL);
        run(13, adc_ctl_pkg::MODE_NORMAL);
        run(1, adc_ctl_pkg::MODE_NORMAL);
        run(2, adc_ctl_pkg::MODE_PARTIAL);
        run(1, adc_ctl_pkg::MODE_PARTIAL);
        run(10, adc_ctl_pkg::MODE_NORMAL);
        run(9, adc_ctl_pkg::MODE_PARTIAL);
        run(5, adc_ctl_pkg::MODE_FULL);
        run(2, adc_ctl_pkg::MODE_FULL);
        run(1, adc_ctl_pkg::MODE_FULL);
        run(10, adc_ctl_pkg::MODE_NORMAL);
        run(32, adc_ctl_pkg::MODE_NORMAL);
        repeat (10) @(posedge clock);
        `CHK(strobes, frames)
        `CHK(notes.size(), 0)
        complete_run();
    end

    // watchdog over the whole sequence
    initial begin
        repeat (12000) @(posedge clock);
        error_cnt++;
        complete_run();
    end
endmodule : dual_adc_power_mode_serial_tb
`default_nettype wire
